// ===== include/hwmon_pkg.sv
// Package for the hardware-monitor digital block: strap layout, codes, counts.
// Assumes a single 100 MHz clock and plain-port control, no register bus.
package hwmon_pkg;

	localparam int CLK_MHZ = 100;

	// Tach period count: 1.5e6/RPM at 2 pulses per turn means one tick per 20 us
	localparam int TACH_TICK_US     = 20;
	localparam int TACH_TICK_CYCLES = TACH_TICK_US * CLK_MHZ;
	localparam int TACH_W           = 12;
	localparam logic [11:0] TACH_MAX   = 12'h0FFF;
	localparam logic [11:0] TACH_MIN   = 12'h0040;
	localparam int FILT_LEN         = 5;

	// Temperature codes, two's complement whole degrees
	localparam logic [7:0] TEMP_OPEN   = 8'h80;
	localparam logic [7:0] TEMP_MIN    = 8'hD8;
	localparam logic [7:0] TEMP_MAX    = 8'h7F;
	localparam int VOLT_LSB_MV         = 8;
	localparam int NUM_TEMP            = 3;
	localparam int NUM_FAN             = 3;

	// Fan duty defaults: 40% of 255 rounds to 102
	localparam logic [7:0] DUTY_40     = 8'h66;
	localparam logic [7:0] DUTY_100    = 8'hFF;

	// Config port pairs
	localparam logic [7:0] CFG_IDX_HI  = 8'h4E;
	localparam logic [7:0] CFG_DAT_HI  = 8'h4F;
	localparam logic [7:0] CFG_IDX_LO  = 8'h2E;
	localparam logic [7:0] CFG_DAT_LO  = 8'h2F;

	// SMBus capacities
	localparam int SMB_NUM_ADDR        = 4;
	localparam int SMB_BLK_RD_MAX      = 17;
	localparam int SMB_BLK_WR_MAX      = 4;

	// Strap bit positions
	localparam int STRAP_TIMING        = 0;
	localparam int STRAP_DUTY          = 1;
	localparam int STRAP_CFG           = 2;
	localparam int STRAP_FAN1          = 3;
	localparam int STRAP_W             = 6;

	typedef struct packed {
		logic [2:0] fan_pwm_mode;
		logic       cfg_port_hi;
		logic       duty_40;
		logic       timing_pins;
	} hwmon_strap_t;

	typedef struct packed {
		logic [7:0] high_limit;
		logic [7:0] high_hyst;
		logic [7:0] low_limit;
		logic [7:0] low_hyst;
	} hwmon_limits_t;

	typedef enum logic [1:0] {
		HWMON_ST_BELOW = 2'b01,
		HWMON_ST_ABOVE = 2'b10
	} hwmon_zone_t;

endpackage

// ===== src/hwmon_tach.sv
// One fan tachometer period counter with a 5-sample filter.
// Assumes tach input synchronous to i_mclk.
`timescale 1ns/1ps
`default_nettype none
module hwmon_tach (
	// Clock and reset
	input  wire logic        i_mclk,
	input  wire logic        i_rst_b,
	// Timing
	input  wire logic        i_tick,
	// Tach input
	input  wire logic        i_tach,
	// Result
	output logic [11:0]      o_count,
	output logic             o_valid
);
	logic [4:0]  filt;
	logic [4:0]  next_filt;
	logic        clean;
	logic        next_clean;
	logic [11:0] run;
	logic [11:0] next_run;
	logic [11:0] next_count;
	logic        next_valid;

	always_comb begin
		next_filt  = {filt[3:0], i_tach};
		next_clean = clean;
		if (&filt)
			next_clean = 1'b1;
		else if (~|filt)
			next_clean = 1'b0;
		next_run   = run;
		next_count = o_count;
		next_valid = o_valid;
		if (clean & ~next_clean) begin
			next_count = run;
			next_valid = (run >= hwmon_pkg::TACH_MIN);
			next_run   = 12'h0000;
		end else if (i_tick && run != hwmon_pkg::TACH_MAX) begin
			next_run = run + 12'h0001;
		end else if (i_tick) begin
			next_count = hwmon_pkg::TACH_MAX;
			next_valid = 1'b0;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			filt    <= 5'h00;
			clean   <= 1'b0;
			run     <= 12'h000;
			o_count <= 12'hFFF;
			o_valid <= 1'b0;
		end else begin
			filt    <= next_filt;
			clean   <= next_clean;
			run     <= next_run;
			o_count <= next_count;
			o_valid <= next_valid;
		end
	end
endmodule
`default_nettype wire

// ===== src/hwmon_temp_chan.sv
// One temperature channel: code encoding, over-temp hysteresis, interrupt zones.
// Assumes raw readings arrive with a one-cycle strobe.
`timescale 1ns/1ps
`default_nettype none
module hwmon_temp_chan (
	// Clock and reset
	input  wire logic                  i_mclk,
	input  wire logic                  i_rst_b,
	// Reading
	input  wire logic                  i_strobe,
	input  wire logic                  i_open,
	input  wire logic signed [8:0]     i_raw,
	input  wire hwmon_pkg::hwmon_limits_t i_lim,
	input  wire logic                  i_irq_clear,
	// Results
	output logic [7:0]                 o_code,
	output logic                       o_ovt,
	output logic                       o_event
);
	logic [7:0] next_code;
	logic       next_ovt;
	logic       next_event;
	hwmon_pkg::hwmon_zone_t hz;
	hwmon_pkg::hwmon_zone_t next_hz;
	hwmon_pkg::hwmon_zone_t lz;
	hwmon_pkg::hwmon_zone_t next_lz;
	logic signed [7:0] t;

	always_comb begin
		// Clamp to -40..127 and flag open sensor
		if (i_open)
			next_code = hwmon_pkg::TEMP_OPEN;
		else if (i_raw > 9'sd127)
			next_code = hwmon_pkg::TEMP_MAX;
		else if (i_raw < -9'sd40)
			next_code = hwmon_pkg::TEMP_MIN;
		else
			next_code = i_raw[7:0];
		t          = signed'(next_code);
		next_ovt   = o_ovt;
		next_hz    = hz;
		next_lz    = lz;
		next_event = 1'b0;
		if (i_strobe && !i_open) begin
			if (t > signed'(i_lim.high_limit))
				next_ovt = 1'b1;
			else if (t < signed'(i_lim.high_hyst))
				next_ovt = 1'b0;
			unique case (hz)
				hwmon_pkg::HWMON_ST_BELOW: if (t > signed'(i_lim.high_limit)) begin
					next_hz = hwmon_pkg::HWMON_ST_ABOVE;
					next_event = 1'b1;
				end
				hwmon_pkg::HWMON_ST_ABOVE: if (t < signed'(i_lim.high_hyst)) begin
					next_hz = hwmon_pkg::HWMON_ST_BELOW;
					next_event = 1'b1;
				end
				default: next_hz = hwmon_pkg::HWMON_ST_BELOW;
			endcase
			unique case (lz)
				hwmon_pkg::HWMON_ST_BELOW: if (t > signed'(i_lim.low_limit)) begin
					next_lz = hwmon_pkg::HWMON_ST_ABOVE;
					next_event = 1'b1;
				end
				hwmon_pkg::HWMON_ST_ABOVE: if (t < signed'(i_lim.low_hyst)) begin
					next_lz = hwmon_pkg::HWMON_ST_BELOW;
					next_event = 1'b1;
				end
				default: next_lz = hwmon_pkg::HWMON_ST_BELOW;
			endcase
		end
		if (!i_strobe)
			next_code = o_code;
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_code  <= 8'h00;
			o_ovt   <= 1'b0;
			o_event <= 1'b0;
			hz      <= hwmon_pkg::HWMON_ST_BELOW;
			lz      <= hwmon_pkg::HWMON_ST_BELOW;
		end else begin
			o_code  <= next_code;
			o_ovt   <= next_ovt;
			o_event <= next_event;
			hz      <= next_hz;
			lz      <= next_lz;
		end
	end
endmodule
`default_nettype wire

// ===== src/hwmon_top.sv
// Hardware-monitor digital core: straps, temperatures, alarm, interrupt, fans.
// Assumes all inputs synchronous to i_mclk; no register bus, plain ports only.
`timescale 1ns/1ps
`default_nettype none
module hwmon_top (
	// Clock and reset
	input  wire logic                         i_mclk,
	input  wire logic                         i_rst_b,
	// Strap pins
	input  wire logic                         i_strap_timing_gpio,
	input  wire logic                         i_strap_default_fan_duty,
	input  wire logic                         i_strap_config_port_select,
	input  wire logic [2:0]                   i_strap_fan_drive_out,
	// Voltage converter
	input  wire logic                         i_volt_strobe,
	input  wire logic [7:0]                   i_volt_raw,
	// Temperature sources
	input  wire logic [2:0]                   i_temp_strobe,
	input  wire logic [2:0]                   i_temp_open,
	input  wire logic [26:0]                  i_temp_raw,
	input  wire hwmon_pkg::hwmon_limits_t     i_temp_limits,
	// SMBus and PECI reading sources
	input  wire logic                         i_smb_strobe,
	input  wire logic [1:0]                   i_smb_slot,
	input  wire logic [7:0]                   i_smb_byte,
	input  wire logic                         i_peci_strobe,
	input  wire logic [7:0]                   i_peci_temp,
	// Interrupt control
	input  wire logic                         i_irq_status_wr,
	input  wire logic [2:0]                   i_irq_status_wdata,
	// Fan control
	input  wire logic [2:0]                   i_tach,
	input  wire logic                         i_duty_wr,
	input  wire logic [23:0]                  i_duty_wdata,
	// Strap results
	output logic                              o_timing_pins_en,
	output logic [7:0]                        o_cfg_index_port,
	output logic [7:0]                        o_cfg_data_port,
	output logic [2:0]                        o_fan_pwm_mode,
	// Readings
	output logic [7:0]                        o_volt_code,
	output logic [23:0]                       o_temp_code,
	output logic [31:0]                       o_smb_temp,
	output logic [7:0]                        o_peci_temp,
	output logic [35:0]                       o_fan_count,
	output logic [2:0]                        o_fan_count_valid,
	// Alarm and interrupt
	output logic                              o_over_temp_alarm_n,
	output logic                              o_wake_event_irq_n,
	output logic [2:0]                        o_irq_status,
	// Fan drive
	output logic [2:0]                        o_fan_drive_out,
	output logic [23:0]                       o_fan_level
);
	hwmon_pkg::hwmon_strap_t strap;
	hwmon_pkg::hwmon_strap_t next_strap;
	logic        strap_done;
	logic        next_strap_done;
	logic [2:0]  ovt;
	logic [2:0]  evt;
	logic [23:0] codes;
	logic [2:0]  next_irq_status;
	logic [7:0]  next_volt_code;
	logic [31:0] next_smb_temp;
	logic [7:0]  next_peci_temp;
	logic [23:0] duty;
	logic [23:0] next_duty;
	logic [7:0]  pwm_phase;
	logic [7:0]  next_pwm_phase;
	logic [2:0]  next_fan_drive_out;
	logic [11:0] tick_cnt;
	logic [11:0] next_tick_cnt;
	logic        tick;
	logic [35:0] counts;
	logic [2:0]  cvalid;

	// Straps latched on the first clock after release, never again
	always_comb begin
		next_strap      = strap;
		next_strap_done = 1'b1;
		if (!strap_done) begin
			next_strap.timing_pins  = i_strap_timing_gpio;
			next_strap.duty_40      = i_strap_default_fan_duty;
			next_strap.cfg_port_hi  = i_strap_config_port_select;
			next_strap.fan_pwm_mode = i_strap_fan_drive_out;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			strap      <= '{fan_pwm_mode: 3'b000, cfg_port_hi: 1'b1, duty_40: 1'b1,
				timing_pins: 1'b1};
			strap_done <= 1'b0;
		end else begin
			strap      <= next_strap;
			strap_done <= next_strap_done;
		end
	end

	// Tach tick divider, 20 us per count
	always_comb begin
		next_tick_cnt = tick_cnt + 12'h001;
		if (tick_cnt == 12'(hwmon_pkg::TACH_TICK_CYCLES - 1))
			next_tick_cnt = 12'h000;
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tick_cnt <= 12'h000;
			tick     <= 1'b0;
		end else begin
			tick_cnt <= next_tick_cnt;
			tick     <= (next_tick_cnt == 12'h000);
		end
	end

	for (genvar g = 0; g < hwmon_pkg::NUM_TEMP; g++) begin : g_temp
		hwmon_temp_chan u_chan (
			.i_mclk      (i_mclk),
			.i_rst_b     (i_rst_b),
			.i_strobe    (i_temp_strobe[g]),
			.i_open      (i_temp_open[g]),
			.i_raw       (signed'(i_temp_raw[g*9 +: 9])),
			.i_lim       (i_temp_limits),
			.i_irq_clear (i_irq_status_wr),
			.o_code      (codes[g*8 +: 8]),
			.o_ovt       (ovt[g]),
			.o_event     (evt[g])
		);
	end

	for (genvar f = 0; f < hwmon_pkg::NUM_FAN; f++) begin : g_fan
		hwmon_tach u_tach (
			.i_mclk  (i_mclk),
			.i_rst_b (i_rst_b),
			.i_tick  (tick),
			.i_tach  (i_tach[f]),
			.o_count (counts[f*12 +: 12]),
			.o_valid (cvalid[f])
		);
	end

	// Status, readings and fan drive
	always_comb begin
		next_irq_status = o_irq_status;
		if (i_irq_status_wr)
			next_irq_status = o_irq_status & ~i_irq_status_wdata;
		// Clear wins over a new event on a pending bit, which is dropped; a pending bit blocks no other channel
		next_irq_status = next_irq_status | (evt & ~o_irq_status);
		next_volt_code = i_volt_strobe ? i_volt_raw : o_volt_code;
		next_smb_temp  = o_smb_temp;
		if (i_smb_strobe)
			next_smb_temp[i_smb_slot*8 +: 8] = i_smb_byte;
		next_peci_temp = i_peci_strobe ? i_peci_temp : o_peci_temp;
		next_duty = duty;
		if (!strap_done)
			next_duty = {3{i_strap_default_fan_duty ? hwmon_pkg::DUTY_40
				: hwmon_pkg::DUTY_100}};
		else if (i_duty_wr)
			next_duty = i_duty_wdata;
		next_pwm_phase = pwm_phase + 8'h01;
		if (pwm_phase == 8'hFE)
			next_pwm_phase = 8'h00;
		for (int k = 0; k < 3; k++)
			// FFh keeps the output high for the whole 255-step frame
			next_fan_drive_out[k] = strap.fan_pwm_mode[k]
				& (pwm_phase < duty[k*8 +: 8]);
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_irq_status    <= 3'b000;
			o_volt_code     <= 8'h00;
			o_smb_temp      <= 32'h0000_0000;
			o_peci_temp     <= 8'h00;
			duty            <= 24'hFF_FFFF;
			pwm_phase       <= 8'h00;
			o_fan_drive_out <= 3'b000;
			// Full drive until the duty strap is read
			o_fan_level     <= 24'hFF_FFFF;
			o_over_temp_alarm_n <= 1'b1;
			o_wake_event_irq_n  <= 1'b1;
			o_temp_code     <= 24'h00_0000;
			o_fan_count     <= 36'hFFF_FFF_FFF;
			o_fan_count_valid <= 3'b000;
			o_timing_pins_en  <= 1'b1;
			o_cfg_index_port  <= hwmon_pkg::CFG_IDX_HI;
			o_cfg_data_port   <= hwmon_pkg::CFG_DAT_HI;
			o_fan_pwm_mode    <= 3'b000;
		end else begin
			o_irq_status    <= next_irq_status;
			o_volt_code     <= next_volt_code;
			o_smb_temp      <= next_smb_temp;
			o_peci_temp     <= next_peci_temp;
			duty            <= next_duty;
			pwm_phase       <= next_pwm_phase;
			o_fan_drive_out <= next_fan_drive_out;
			o_fan_level     <= duty;
			o_over_temp_alarm_n <= ~|ovt;
			o_wake_event_irq_n  <= ~|next_irq_status;
			o_temp_code     <= codes;
			o_fan_count     <= counts;
			o_fan_count_valid <= cvalid;
			o_timing_pins_en  <= strap.timing_pins;
			o_cfg_index_port  <= strap.cfg_port_hi ? hwmon_pkg::CFG_IDX_HI
				: hwmon_pkg::CFG_IDX_LO;
			o_cfg_data_port   <= strap.cfg_port_hi ? hwmon_pkg::CFG_DAT_HI
				: hwmon_pkg::CFG_DAT_LO;
			o_fan_pwm_mode    <= strap.fan_pwm_mode;
		end
	end
endmodule
`default_nettype wire

// ===== verif/hwmon_sense_model.sv
// Model of the remote sensors and fans around the monitor core.
// Assumes the bench raises a reading request just after a falling edge.
`timescale 1ns/1ps
`default_nettype none
module hwmon_sense_model (
	// Clock
	input  wire logic              i_mclk,
	// Reading request
	input  wire logic              i_req,
	input  wire logic [1:0]        i_ch,
	input  wire logic signed [8:0] i_val,
	input  wire logic              i_open,
	// Sensor and fan lines
	output logic [2:0]             o_strobe,
	output logic [2:0]             o_open,
	output logic [26:0]            o_raw,
	output logic [2:0]             o_tach
);
	logic [10:0] tick;
	// Outside a reading the lanes carry inverted junk, never a usable value
	assign o_strobe = i_req ? 3'h1 << i_ch : 3'h0;
	assign o_open   = {3{i_req ? i_open : ~i_open}};
	assign o_raw    = {3{i_req ? i_val : ~i_val}};
	initial begin
		tick = 11'h000;
		o_tach = 3'h0;
	end
	// Fast fans, one line changing every 2048 clocks so each toggles every 6144, period far below the count floor, staggered phases
	always @(negedge i_mclk) begin
		tick <= tick + 11'h001;
		if (tick == 11'h000) o_tach <= {o_tach[1:0], ~o_tach[2]};
	end
endmodule
`default_nettype wire

// ===== verif/hwmon_chk.sv
// Checker for the hardware-monitor core, bound to its top module.
// Assumes every port is sampled on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module hwmon_chk (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_b,
	// Inputs watched
	input wire logic i_volt_strobe,
	input wire logic [7:0] i_volt_raw,
	input wire logic [2:0] i_temp_strobe,
	input wire logic [2:0] i_temp_open,
	input wire logic [26:0] i_temp_raw,
	input wire hwmon_pkg::hwmon_limits_t i_temp_limits,
	input wire logic i_peci_strobe,
	input wire logic [7:0] i_peci_temp,
	input wire logic i_irq_status_wr,
	input wire logic [2:0] i_irq_status_wdata,
	// Outputs watched
	input wire logic o_timing_pins_en,
	input wire logic [7:0] o_cfg_index_port,
	input wire logic [7:0] o_cfg_data_port,
	input wire logic [2:0] o_fan_pwm_mode,
	input wire logic [7:0] o_volt_code,
	input wire logic [23:0] o_temp_code,
	input wire logic [7:0] o_peci_temp,
	input wire logic [35:0] o_fan_count,
	input wire logic [2:0] o_fan_count_valid,
	input wire logic o_over_temp_alarm_n,
	input wire logic o_wake_event_irq_n,
	input wire logic [2:0] o_irq_status,
	input wire logic [2:0] o_fan_drive_out
);
	logic [1:0] up;
	logic [1:0] next_up;
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);
	// Straps settle two edges after release, so hold is checked from the third
	always_comb next_up = (up == 2'h3) ? up : up + 2'h1;
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) up <= 2'h0;
		else up <= next_up;
	end
	strap_hold_a: assert property (
		up == 2'h3 |-> $stable({o_fan_pwm_mode, o_timing_pins_en, o_cfg_index_port}))
		else $error("strap outputs moved");
	cfg_pair_a: assert property (
		o_cfg_data_port == o_cfg_index_port + 8'h01
		&& (o_cfg_index_port == 8'h4E || o_cfg_index_port == 8'h2E))
		else $error("config port pair wrong");
	volt_echo_a: assert property (
		i_volt_strobe |=> o_volt_code == $past(i_volt_raw))
		else $error("voltage code wrong");
	peci_echo_a: assert property (
		i_peci_strobe |=> o_peci_temp == $past(i_peci_temp))
		else $error("peci reading wrong");
	open_code_a: assert property (
		i_temp_strobe[1] && i_temp_open[1] |-> ##2 o_temp_code[15:8] == 8'h80)
		else $error("open sensor code wrong");
	ovt_set_a: assert property (
		i_temp_strobe[0] && !i_temp_open[0] && $signed(i_temp_raw[8:0])
		> $signed({i_temp_limits.high_limit[7], i_temp_limits.high_limit})
		|-> ##2 !o_over_temp_alarm_n)
		else $error("alarm not raised");
	irq_level_a: assert property (
		(|o_irq_status) && $past(|o_irq_status) |-> !o_wake_event_irq_n)
		else $error("interrupt line idle");
	clear_bit_a: assert property (
		i_irq_status_wr && i_irq_status_wdata[0] && !$past(i_temp_strobe[0])
		|=> !o_irq_status[0])
		else $error("status bit not cleared");
	dac_quiet_a: assert property (
		!o_fan_pwm_mode[0] && $past(!o_fan_pwm_mode[0]) |-> !o_fan_drive_out[0])
		else $error("pwm wave in dac mode");
	count_floor_a: assert property (
		o_fan_count_valid[0] |-> o_fan_count[11:0] >= 12'h040)
		else $error("fan count below floor");
endmodule
bind hwmon_top hwmon_chk hwmon_chk_inst (.*);
`default_nettype wire

// ===== verif/hw_monitor_strap_temp_fan_test.sv
// Self-checking bench for the hardware-monitor core.
// Assumes the sensor model and the bound checker compile alongside.
`timescale 1ns/1ps
`default_nettype none
module hw_monitor_strap_temp_fan_test;
	logic i_mclk, i_rst_b, i_strap_timing_gpio, i_strap_default_fan_duty;
	logic i_strap_config_port_select, i_volt_strobe, i_smb_strobe, i_peci_strobe;
	logic i_irq_status_wr, i_duty_wr, o_timing_pins_en, o_over_temp_alarm_n, o_wake_event_irq_n;
	logic [2:0] i_strap_fan_drive_out, i_temp_strobe, i_temp_open, i_irq_status_wdata, i_tach;
	logic [2:0] o_fan_pwm_mode, o_fan_count_valid, o_irq_status, o_fan_drive_out;
	logic [7:0] i_volt_raw, i_smb_byte, i_peci_temp, o_cfg_index_port, o_cfg_data_port;
	logic [7:0] o_volt_code, o_peci_temp;
	logic [1:0] i_smb_slot, ch;
	logic [26:0] i_temp_raw;
	logic [23:0] i_duty_wdata, o_temp_code, o_fan_level, dw;
	logic [31:0] o_smb_temp, sm;
	logic [35:0] o_fan_count;
	logic [5:0] sp;
	logic signed [8:0] val;
	logic req, op;
	hwmon_pkg::hwmon_limits_t i_temp_limits;
	int seed = 7;
	int n_mismatch = 0;
	int checks_done = 0;
	hwmon_top hwmon_top_inst (.*);
	hwmon_sense_model hwmon_sense_model_inst (.i_mclk, .i_req(req), .i_ch(ch), .i_val(val),
		.i_open(op), .o_strobe(i_temp_strobe), .o_open(i_temp_open), .o_raw(i_temp_raw),
		.o_tach(i_tach));
	task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(negedge i_mclk);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic temp(input logic [1:0] c, input int v, input logic o);
		ch = c;
		val = v[8:0];
		op = o;
		req = 1'b1;
		step(1);
		req = 1'b0;
		step(1);
	endtask
	task automatic clr(input logic [2:0] w);
		i_irq_status_wr = 1'b1;
		i_irq_status_wdata = w;
		step(1);
		i_irq_status_wr = 1'b0;
		step(2);
	endtask
	function automatic logic [7:0] exp_code(input int v);
		if (v < -40) return 8'hD8;
		if (v > 127) return 8'h7F;
		return v[7:0];
	endfunction
	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	initial begin
		int hi [3];
		int v;
		static int tv [8] = '{-40, -1, 1, 90, 127, -90, 200, 0};
		{i_volt_strobe, i_smb_strobe, i_peci_strobe, i_irq_status_wr, i_duty_wr, req, op} = '0;
		{i_volt_raw, i_smb_byte, i_peci_temp, i_smb_slot, i_irq_status_wdata, ch, val} = '0;
		i_duty_wdata = 24'h00_0000;
		i_temp_limits = '{8'h64, 8'h5A, 8'h14, 8'h0A};
		i_rst_b = 1'b0;
		sp = 6'($random(seed));
		// Second pass flips every strap and resets in mid-run
		for (int r = 0; r < 2; r++) begin
			if (r == 1) sp = ~sp;
			{i_strap_fan_drive_out, i_strap_config_port_select, i_strap_default_fan_duty,
				i_strap_timing_gpio} = sp;
			i_rst_b = 1'b0;
			step(12);
			chk("rst_strap", {o_timing_pins_en, o_cfg_index_port, o_fan_pwm_mode}, 12'hA70);
			chk("rst_level", o_fan_level, 24'hFF_FFFF);
			chk("rst_count", {o_fan_count_valid, o_fan_count}, 39'h0F_FFFF_FFFF);
			chk("rst_alarm", {o_over_temp_alarm_n, o_wake_event_irq_n}, 2'h3);
			i_rst_b = 1'b1;
			step(3);
			chk("strap_out", {o_timing_pins_en, o_fan_pwm_mode}, {sp[0], sp[5:3]});
			chk("cfg_port", {o_cfg_index_port, o_cfg_data_port},
				sp[2] ? 16'h4E4F : 16'h2E2F);
			chk("duty_init", o_fan_level, {3{sp[1] ? 8'h66 : 8'hFF}});
			{i_strap_fan_drive_out, i_strap_config_port_select, i_strap_default_fan_duty,
				i_strap_timing_gpio} = ~sp;
			step(3);
			chk("strap_hold", {o_timing_pins_en, o_fan_pwm_mode, o_cfg_index_port},
				{sp[0], sp[5:3], sp[2] ? 8'h4E : 8'h2E});
		end
		for (int k = 0; k < 4; k++) begin
			i_volt_raw = 8'($random(seed));
			i_peci_temp = 8'($random(seed));
			i_smb_byte = 8'($random(seed));
			i_smb_slot = k[1:0];
			sm[k*8 +: 8] = i_smb_byte;
			{i_volt_strobe, i_peci_strobe, i_smb_strobe} = 3'h7;
			step(1);
			{i_volt_strobe, i_peci_strobe, i_smb_strobe} = 3'h0;
			chk("volt", o_volt_code, i_volt_raw);
			chk("peci", o_peci_temp, i_peci_temp);
			step(1);
		end
		chk("smb", o_smb_temp, sm);
		// Table corners first, then random readings past both clamp ends
		for (int k = 0; k < 16; k++) begin
			v = (k < 8) ? tv[k] : $random(seed) % 160 + 30;
			temp(2'(k % 3), v, 1'b0);
			chk("temp", o_temp_code[(k % 3)*8 +: 8], exp_code(v));
		end
		temp(2'h1, 50, 1'b1);
		chk("open", o_temp_code[15:8], 8'h80);
		for (int k = 0; k < 3; k++) temp(2'(k), 50, 1'b0);
		clr(3'h7);
		chk("irq_clear", {o_irq_status, o_wake_event_irq_n}, 4'h1);
		temp(2'h0, 110, 1'b0);
		step(1);
		chk("irq_set", {o_irq_status, o_wake_event_irq_n, o_over_temp_alarm_n}, 5'h04);
		temp(2'h0, 95, 1'b0);
		chk("ovt_hold", o_over_temp_alarm_n, 1'b0);
		temp(2'h0, 80, 1'b0);
		chk("ovt_free", o_over_temp_alarm_n, 1'b1);
		clr(3'h0);
		clr(3'h2);
		chk("irq_keep", o_irq_status, 3'h1);
		clr(3'h1);
		chk("irq_drop", {o_irq_status, o_wake_event_irq_n}, 4'h1);
		temp(2'h0, 110, 1'b0);
		chk("irq_rearm", o_irq_status, 3'h1);
		for (int r = 0; r < 2; r++) begin
			dw = r ? 24'h00_FF01 : 24'($random(seed));
			i_duty_wr = 1'b1;
			i_duty_wdata = dw;
			step(1);
			i_duty_wr = 1'b0;
			// A new duty takes effect on the next clock, without waiting for the frame boundary
			step(256);
			chk("level", o_fan_level, dw);
			hi = '{0, 0, 0};
			repeat (255) begin
				step(1);
				for (int k = 0; k < 3; k++) hi[k] += o_fan_drive_out[k];
			end
			for (int k = 0; k < 3; k++)
				chk("pwm_high", 40'(hi[k]), sp[3+k] ? 40'(dw[k*8 +: 8]) : 40'h0);
		end
		report_and_stop();
	end
endmodule
`default_nettype wire
